//--- include/sfpi_pkg.sv
// Constants, encodings and state types for the serial flash pin front end.
// Assumes one system clock that is much faster than the serial clock on the pins.

package sfpi_pkg;

    // ------------------------------------------------------------------
    // Clock and lane modes
    // ------------------------------------------------------------------
    localparam int unsigned CLK_SYS_HZ = 40000000;

    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DUAL   = 2'h1;
    localparam logic [1:0] MODE_QUAD   = 2'h2;

    localparam logic [3:0] BITS_SINGLE = 4'h1;
    localparam logic [3:0] BITS_DUAL   = 4'h2;
    localparam logic [3:0] BITS_QUAD   = 4'h4;
    localparam logic [3:0] BYTE_BITS   = 4'h8;

    // ------------------------------------------------------------------
    // Synchroniser bit positions
    // ------------------------------------------------------------------
    localparam int unsigned SYNC_WIDTH = 7;
    localparam int unsigned SYN_CS     = 0;
    localparam int unsigned SYN_CLK    = 1;
    localparam int unsigned SYN_L0     = 2;
    localparam int unsigned SYN_L1     = 3;
    localparam int unsigned SYN_L2     = 4;
    localparam int unsigned SYN_L3     = 5;
    localparam int unsigned SYN_RST    = 6;
    // Chip select resets as low, so a select held low through reset is never taken as an edge.
    localparam logic [6:0]  SYNC_RESET = 7'h7E;

    // ------------------------------------------------------------------
    // Protection geometry
    // ------------------------------------------------------------------
    localparam int unsigned  SECTOR_BITS  = 12;
    localparam logic [12:0]  SECTOR_TOTAL = 13'h1000;
    localparam logic [12:0]  SECTOR_ONE   = 13'h0001;
    localparam logic [12:0]  BLOCK_SECTS  = 13'h0010;
    localparam logic [12:0]  SEC_MAX_SECT = 13'h0008;
    localparam logic [2:0]   BP_NONE      = 3'h0;
    localparam logic [2:0]   BP_ALL       = 3'h7;

    // ------------------------------------------------------------------
    // Link states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_UNARMED = 2'b00,
        ST_DESEL   = 2'b01,
        ST_ACTIVE  = 2'b10,
        ST_PAUSED  = 2'b11
    } sfpi_state_t;

endpackage : sfpi_pkg

//--- include/sfpi_prot_if.sv
// Interface carrying protection fields to the protection checker and its verdicts back.
// Assumes both ends sit on clk_sys.

`timescale 1ns/1ps

interface sfpi_prot_if;
    logic        protectComplement;
    logic        sectorGranularity;
    logic        topBottomSelect;
    logic [2:0]  blockProtect;
    logic [1:0]  statusProtectBits;
    logic        writeProtActive;
    logic [11:0] sectorAddr;
    logic        sectorProtected;
    logic        statusWriteOk;

    modport checker_end (
        input  protectComplement,
        input  sectorGranularity,
        input  topBottomSelect,
        input  blockProtect,
        input  statusProtectBits,
        input  writeProtActive,
        input  sectorAddr,
        output sectorProtected,
        output statusWriteOk
    );

    modport front_end (
        output protectComplement,
        output sectorGranularity,
        output topBottomSelect,
        output blockProtect,
        output statusProtectBits,
        output writeProtActive,
        output sectorAddr,
        input  sectorProtected,
        input  statusWriteOk
    );
endinterface : sfpi_prot_if

//--- rtl/sfpi_pin_front.sv
// Pin front end of a serial flash: select, sampling and driving of lanes, pause, reset.
// Assumes clk_sys runs well above four times the serial clock so every edge is seen.

`timescale 1ns/1ps

module sfpi_pin_front (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Serial pins
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic [3:0]  laneIn,
    output logic      [3:0]  laneOut,
    output logic      [3:0]  laneOe,
    input  wire logic        resetPinN,
    // Configuration bits
    input  wire logic        quadEnableBit,
    input  wire logic        pauseResetSel,
    input  wire logic        protectComplement,
    input  wire logic        sectorGranularity,
    input  wire logic        topBottomSelect,
    input  wire logic [2:0]  blockProtect,
    input  wire logic [1:0]  statusProtectBits,
    // Instruction decoder side
    input  wire logic [1:0]  laneMode,
    input  wire logic        outPhase,
    input  wire logic [7:0]  txByte,
    output logic             txTake,
    output logic      [7:0]  rxByte,
    output logic             rxValid,
    output logic             frameStart,
    output logic             frameEnd,
    output logic             selected,
    output logic             paused,
    output logic             quadRefused,
    // Internal operations
    input  wire logic        opStart,
    input  wire logic        statusWrReq,
    input  wire logic        opDone,
    output logic             opBusy,
    output logic             statusWrRefused,
    input  wire logic [11:0] sectorAddr,
    output logic             sectorProtected,
    output logic             hwResetActive
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        sfpi_pkg::sfpi_state_t state;
        logic                  clkPrev;
        logic [3:0]            out;
        logic [3:0]            oe;
        logic [7:0]            rxShift;
        logic [3:0]            rxCnt;
        logic [7:0]            rxByte;
        logic                  rxValid;
        logic [7:0]            txShift;
        logic [3:0]            txCnt;
        logic                  txTake;
        logic                  frameStart;
        logic                  frameEnd;
        logic                  quadRefused;
        logic                  opBusy;
        logic                  statusWrRefused;
        logic                  hwReset;
        logic                  selected;
        logic                  paused;
    } sfpi_front_t;

    sfpi_front_t r_r;
    sfpi_front_t r_nxt;

    // ------------------------------------------------------------------
    // Pin synchronisers and protection checker
    // ------------------------------------------------------------------
    logic [sfpi_pkg::SYNC_WIDTH-1:0] pinRaw;
    logic [sfpi_pkg::SYNC_WIDTH-1:0] pinLvl;

    assign pinRaw = {resetPinN, laneIn, sclk, csN};

    sfpi_sync #(
        .WIDTH (sfpi_pkg::SYNC_WIDTH),
        .INIT  (sfpi_pkg::SYNC_RESET)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .pinIn    (pinRaw),
        .levelOut (pinLvl)
    );

    sfpi_prot_if protBus ();

    // Write-protect is a pin function only while the lane is not a quad data lane.
    assign protBus.protectComplement = protectComplement;
    assign protBus.sectorGranularity = sectorGranularity;
    assign protBus.topBottomSelect   = topBottomSelect;
    assign protBus.blockProtect      = blockProtect;
    assign protBus.statusProtectBits = statusProtectBits;
    assign protBus.writeProtActive   = !quadEnableBit && !pinLvl[sfpi_pkg::SYN_L2];
    assign protBus.sectorAddr        = sectorAddr;

    sfpi_protect u_protect (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .prot    (protBus)
    );

    // ------------------------------------------------------------------
    // Derived pin conditions
    // ------------------------------------------------------------------
    logic       csLow;
    logic       clkLvl;
    logic       riseEdge;
    logic       fallEdge;
    logic       hwRst;
    logic       pauseReq;
    logic [1:0] effMode;
    logic [3:0] stepBits;

    // Shared pin: pause or reset by select bit, and neither while it is lane 3.
    always_comb begin
        csLow    = !pinLvl[sfpi_pkg::SYN_CS];
        clkLvl   = pinLvl[sfpi_pkg::SYN_CLK];
        riseEdge = clkLvl && !r_r.clkPrev;
        fallEdge = !clkLvl && r_r.clkPrev;
        hwRst    = !pinLvl[sfpi_pkg::SYN_RST]
                || (!quadEnableBit && pauseResetSel && !pinLvl[sfpi_pkg::SYN_L3]);
        pauseReq = !quadEnableBit && !pauseResetSel
                && !pinLvl[sfpi_pkg::SYN_L3] && csLow;
        if (laneMode == sfpi_pkg::MODE_QUAD && !quadEnableBit) begin
            effMode = sfpi_pkg::MODE_SINGLE;
        end else begin
            effMode = laneMode;
        end
        case (effMode)
            sfpi_pkg::MODE_DUAL: begin
                stepBits = sfpi_pkg::BITS_DUAL;
            end
            sfpi_pkg::MODE_QUAD: begin
                stepBits = sfpi_pkg::BITS_QUAD;
            end
            default: begin
                stepBits = sfpi_pkg::BITS_SINGLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Lanes sampled together with the clock so the data lines up with the edge seen.
    logic [3:0] laneInS;

    assign laneInS = pinLvl[sfpi_pkg::SYN_L3:sfpi_pkg::SYN_L0];

    logic [7:0] word;
    logic [3:0] cntSum;

    // Edges are taken from the filtered clock level, so modes 0 and 3 behave the same.
    always_comb begin
        r_nxt                 = r_r;
        word                  = r_r.txShift;
        cntSum                = '0;
        r_nxt.clkPrev         = clkLvl;
        r_nxt.rxValid         = 1'b0;
        r_nxt.txTake          = 1'b0;
        r_nxt.frameStart      = 1'b0;
        r_nxt.frameEnd        = 1'b0;
        r_nxt.statusWrRefused = 1'b0;
        r_nxt.hwReset         = hwRst;
        r_nxt.quadRefused     = laneMode == sfpi_pkg::MODE_QUAD && !quadEnableBit;

        case (r_r.state)
            sfpi_pkg::ST_UNARMED: begin
                r_nxt.oe = 4'h0;
                if (!csLow) begin
                    r_nxt.state = sfpi_pkg::ST_DESEL;
                end
            end
            sfpi_pkg::ST_DESEL: begin
                r_nxt.oe = 4'h0;
                if (csLow) begin
                    r_nxt.state      = sfpi_pkg::ST_ACTIVE;
                    r_nxt.frameStart = 1'b1;
                    r_nxt.rxCnt      = 4'h0;
                    r_nxt.txCnt      = 4'h0;
                end
            end
            sfpi_pkg::ST_ACTIVE: begin
                if (!csLow) begin
                    r_nxt.state    = sfpi_pkg::ST_DESEL;
                    r_nxt.oe       = 4'h0;
                    r_nxt.frameEnd = 1'b1;
                end else if (!clkLvl && pauseReq) begin
                    // Pause only takes hold with the clock low, mid-bit pauses wait a fall.
                    r_nxt.state = sfpi_pkg::ST_PAUSED;
                    r_nxt.oe    = 4'h0;
                end else begin
                    if (riseEdge && !outPhase) begin
                        case (effMode)
                            sfpi_pkg::MODE_DUAL: begin
                                r_nxt.rxShift = {r_r.rxShift[5:0], laneInS[1:0]};
                            end
                            sfpi_pkg::MODE_QUAD: begin
                                r_nxt.rxShift = {r_r.rxShift[3:0], laneInS};
                            end
                            default: begin
                                r_nxt.rxShift = {r_r.rxShift[6:0], laneInS[0]};
                            end
                        endcase
                        cntSum = r_r.rxCnt + stepBits;
                        if (cntSum >= sfpi_pkg::BYTE_BITS) begin
                            r_nxt.rxByte  = r_nxt.rxShift;
                            r_nxt.rxValid = 1'b1;
                            r_nxt.rxCnt   = 4'h0;
                        end else begin
                            r_nxt.rxCnt = cntSum;
                        end
                    end
                    if (!outPhase) begin
                        r_nxt.oe    = 4'h0;
                        r_nxt.txCnt = 4'h0;
                    end else if (fallEdge) begin
                        if (r_r.txCnt == 4'h0) begin
                            word         = txByte;
                            r_nxt.txTake = 1'b1;
                        end
                        case (effMode)
                            sfpi_pkg::MODE_DUAL: begin
                                r_nxt.out = {2'b00, word[7:6]};
                                r_nxt.oe  = 4'h3;
                            end
                            sfpi_pkg::MODE_QUAD: begin
                                r_nxt.out = word[7:4];
                                r_nxt.oe  = 4'hF;
                            end
                            default: begin
                                r_nxt.out = {2'b00, word[7], 1'b0};
                                r_nxt.oe  = 4'h2;
                            end
                        endcase
                        r_nxt.txShift = word << stepBits;
                        cntSum        = r_r.txCnt + stepBits;
                        r_nxt.txCnt   = cntSum & 4'h7;
                    end
                end
            end
            sfpi_pkg::ST_PAUSED: begin
                r_nxt.oe = 4'h0;
                if (!csLow) begin
                    r_nxt.state    = sfpi_pkg::ST_DESEL;
                    r_nxt.frameEnd = 1'b1;
                end else if (!clkLvl && !pauseReq) begin
                    r_nxt.state = sfpi_pkg::ST_ACTIVE;
                end
            end
            default: begin
                r_nxt.state = sfpi_pkg::ST_UNARMED;
                r_nxt.oe    = 4'h0;
            end
        endcase

        // Internal cycles ignore chip select; start wins over a done in the same cycle.
        if (opDone) begin
            r_nxt.opBusy = 1'b0;
        end
        if (opStart && !hwRst) begin
            r_nxt.opBusy = 1'b1;
        end
        if (statusWrReq && !hwRst) begin
            if (protBus.statusWriteOk) begin
                r_nxt.opBusy = 1'b1;
            end else begin
                r_nxt.statusWrRefused = 1'b1;
            end
        end

        // Hardware reset aborts frame state, lane drive and busy, and requires a fresh select edge afterwards.
        if (hwRst) begin
            r_nxt.state  = sfpi_pkg::ST_UNARMED;
            r_nxt.oe     = 4'h0;
            r_nxt.opBusy = 1'b0;
            r_nxt.rxCnt  = 4'h0;
            r_nxt.txCnt  = 4'h0;
        end

        // Status levels follow the next state so these ports come straight from flops.
        r_nxt.selected = r_nxt.state == sfpi_pkg::ST_ACTIVE;
        r_nxt.paused   = r_nxt.state == sfpi_pkg::ST_PAUSED;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_r         <= '0;
            r_r.state   <= sfpi_pkg::ST_UNARMED;
            r_r.clkPrev <= 1'b0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign laneOut         = r_r.out;
    assign laneOe          = r_r.oe;
    assign txTake          = r_r.txTake;
    assign rxByte          = r_r.rxByte;
    assign rxValid         = r_r.rxValid;
    assign frameStart      = r_r.frameStart;
    assign frameEnd        = r_r.frameEnd;
    assign selected        = r_r.selected;
    assign paused          = r_r.paused;
    assign quadRefused     = r_r.quadRefused;
    assign opBusy          = r_r.opBusy;
    assign statusWrRefused = r_r.statusWrRefused;
    assign sectorProtected = protBus.sectorProtected;
    assign hwResetActive   = r_r.hwReset;

endmodule : sfpi_pin_front

//--- rtl/sfpi_protect.sv
// Status write permission and sector protection check.
// Assumes protection fields are stable configuration bits from the status registers.

`timescale 1ns/1ps

module sfpi_protect (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Protection fields and verdicts
    sfpi_prot_if.checker_end prot
);

    typedef struct packed {
        logic sectorProtected;
        logic statusWriteOk;
    } sfpi_prot_t;

    sfpi_prot_t  r_r;
    sfpi_prot_t  r_nxt;
    logic [12:0] span;
    logic        inRegion;

    // Region size in sectors: below BP_ALL, small granularity stops at eight sectors, else 64KB blocks.
    always_comb begin
        span = '0;
        if (prot.blockProtect == sfpi_pkg::BP_ALL) begin
            span = sfpi_pkg::SECTOR_TOTAL;
        end else if (prot.blockProtect != sfpi_pkg::BP_NONE) begin
            if (prot.sectorGranularity) begin
                span = sfpi_pkg::SECTOR_ONE << (prot.blockProtect - 3'h1);
                if (span > sfpi_pkg::SEC_MAX_SECT) begin
                    span = sfpi_pkg::SEC_MAX_SECT;
                end
            end else begin
                span = sfpi_pkg::BLOCK_SECTS << (prot.blockProtect - 3'h1);
            end
        end
        if (prot.topBottomSelect) begin
            inRegion = {1'b0, prot.sectorAddr} < span;
        end else begin
            inRegion = {1'b0, prot.sectorAddr} >= (sfpi_pkg::SECTOR_TOTAL - span);
        end
        r_nxt                 = r_r;
        r_nxt.sectorProtected = inRegion ^ prot.protectComplement;
        // Lock bit one always refuses; lock bit zero refuses only while the pin is asserted.
        r_nxt.statusWriteOk   = !prot.statusProtectBits[1]
                              && !(prot.statusProtectBits[0] && prot.writeProtActive);
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign prot.sectorProtected = r_r.sectorProtected;
    assign prot.statusWriteOk   = r_r.statusWriteOk;

endmodule : sfpi_protect

//--- rtl/sfpi_sync.sv
// Three-stage pin synchroniser with an agreement filter.
// Assumes inputs are asynchronous to clk_sys; output moves when stages two and three agree.

`timescale 1ns/1ps

module sfpi_sync #(
    parameter int unsigned WIDTH = sfpi_pkg::SYNC_WIDTH,
    parameter logic [WIDTH-1:0] INIT = sfpi_pkg::SYNC_RESET
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Pins in, filtered levels out
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] levelOut
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } sfpi_sync_t;

    sfpi_sync_t r_r;
    sfpi_sync_t r_nxt;

    // Stage one is read only by stage two; the filter looks at stages two and three.
    always_comb begin
        r_nxt    = r_r;
        r_nxt.s1 = pinIn;
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (r_r.s2[i] == r_r.s3[i]) begin
                r_nxt.lvl[i] = r_r.s3[i];
            end
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_r <= {INIT, INIT, INIT, INIT};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign levelOut = r_r.lvl;

endmodule : sfpi_sync

//--- verif/sfpi_host_model.sv
// Host controller model: chip select, serial clock in mode 0, lanes.
// Assumes the bench calls xfer; pins change only after falling clk_sys edges.
`timescale 1ns/1ps
module sfpi_host_model (
    // Clock
    input wire logic       clk_sys,
    // Pins
    output logic           csN,
    output logic           sclk,
    output logic     [3:0] laneIn,
    input wire logic [3:0] laneOut,
    input wire logic [3:0] laneOe
);
    int half = 5; // Above four system cycles so the synchroniser sees every edge.
    // Chip select starts low so no select edge exists after power-up.
    initial begin
        csN = 1'b0;
        sclk = 1'b0;
        laneIn = 4'hF;
    end
    // One frame of w-bit units, MSB first; a read samples each unit at the next rise.
    task automatic xfer(input int w, input logic [7:0] tx, input bit rd, output logic [7:0] rx);
        logic [3:0] m;
        logic [3:0] pin;
        m = (w == 1 && rd) ? 4'h2 : 4'((1 << w) - 1);
        rx = 8'h00;
        csN = 1'b0;
        for (int i = 0; i < 8 / w + int'(rd); i++) begin
            if (rd) laneIn = laneIn ^ m; // Released lanes toggle so stale values never match.
            else laneIn = (laneIn & ~m) | (4'(tx >> (8 - w * (i + 1))) & m);
            repeat (half) @(negedge clk_sys);
            if (rd && i > 0) begin
                pin = (laneOut & laneOe) | (~laneOut & ~laneOe); // Floating lanes read inverted.
                rx = (rx << w) | 8'(w == 1 ? 4'(pin[1]) : (pin & m));
            end
            sclk = 1'b1;
            repeat (half) @(negedge clk_sys);
            sclk = 1'b0;
        end
        repeat (half) @(negedge clk_sys);
        csN = 1'b1;
        laneIn = 4'hF;
        repeat (2 * half) @(negedge clk_sys);
    endtask : xfer
endmodule : sfpi_host_model

//--- verif/sfpi_pin_front_assertions.sv
// Concurrent checks on the ports of the serial flash pin front end.
// Assumes it is bound to sfpi_pin_front; pins are asynchronous to clk_sys.
`timescale 1ns/1ps
module sfpi_pin_front_assertions (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Pins
    input wire logic       csN,
    input wire logic [3:0] laneIn,
    input wire logic [3:0] laneOe,
    input wire logic       resetPinN,
    // Configuration and operations
    input wire logic       quadEnableBit,
    input wire logic       outPhase,
    input wire logic       opStart,
    input wire logic       opDone,
    input wire logic       opBusy,
    input wire logic       statusWrReq,
    input wire logic [1:0] statusProtectBits,
    input wire logic       statusWrRefused,
    input wire logic       hwResetActive
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A pin level held six cycles has passed the synchroniser and its filter.
    sequence wp_low_s; (!laneIn[2] && !quadEnableBit)[*6]; endsequence
    sequence srp_req_s; statusWrReq && statusProtectBits == 2'h1; endsequence
    sequence no_rst_s; (resetPinN && !hwResetActive)[*6]; endsequence
    a_desel_float: assert property (csN[*8] |-> laneOe == 4'h0)
        else $error("lanes driven while deselected");
    a_idle_no_drive: assert property ((!outPhase)[*3] |-> laneOe == 4'h0)
        else $error("lanes driven outside data out");
    a_oe_lane_set: assert property (laneOe != 4'h0 |-> laneOe inside {4'h2, 4'h3, 4'hF})
        else $error("illegal lane enable set");
    a_op_sets_busy: assert property (opStart |=> opBusy)
        else $error("busy not raised by start");
    a_busy_holds: assert property (no_rst_s ##0 (opBusy && !opDone) |=> opBusy)
        else $error("busy dropped early");
    a_wp_refuses: assert property (wp_low_s ##0 srp_req_s |=> statusWrRefused)
        else $error("protected status write not refused");
    a_qe_frees_wp: assert property (quadEnableBit[*6] ##0 srp_req_s |=> !statusWrRefused)
        else $error("write protect active in quad");
    a_reset_pin: assert property ((!resetPinN)[*8] |-> hwResetActive && laneOe == 4'h0)
        else $error("dedicated reset ignored");
endmodule : sfpi_pin_front_assertions

//--- verif/sfpi_pin_front_tb.sv
// Self-checking bench for the serial flash pin front end.
// Assumes the checker and host model are compiled first.
`timescale 1ns/1ps
module sfpi_pin_front_tb;
    logic       clk_sys, rst_n, csN, sclk, resetPinN, quadEnableBit, pauseResetSel, outPhase;
    logic       protectComplement, sectorGranularity, topBottomSelect, txTake, rxValid;
    logic       frameStart, frameEnd, selected, paused, quadRefused, opStart, statusWrReq;
    logic       opDone, opBusy, statusWrRefused, sectorProtected, hwResetActive;
    logic [3:0] laneIn, laneOut, laneOe;
    logic [2:0] blockProtect;
    logic [1:0] statusProtectBits, laneMode;
    logic [7:0] txByte, rxByte, rx;
    logic [11:0] sectorAddr;
    logic [7:0] exp_q[$];
    int n_fail = 0, n_compared = 0, seed = 32'hfdb9;
    sfpi_pin_front i_sfpi_pin_front (.*);
    sfpi_host_model i_sfpi_host_model (.*);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        @(negedge clk_sys);
    endtask : pulse
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // Every captured byte must be the next one the model expects.
    always @(negedge clk_sys) if (rxValid) begin
        check(8'(selected), 8'h01);
        if (exp_q.size() == 0) check(8'h01, 8'h00);
        else check(rxByte, exp_q.pop_front());
    end
    // Watchdog: a hang counts as a mismatch.
    initial begin
        #2ms n_fail++;
        tally_and_finish();
    end
    initial begin
        {rst_n, resetPinN, quadEnableBit, pauseResetSel, outPhase, opStart} = 6'h10;
        {opDone, statusWrReq, protectComplement, sectorGranularity, topBottomSelect} = 5'h00;
        {laneMode, txByte, blockProtect, statusProtectBits, sectorAddr} = '0;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        i_sfpi_host_model.xfer(1, 8'hA5, 1'b0, rx);
        $display("test unarmed done");
        quadEnableBit = 1'b1;
        for (int m = 0; m < 3; m++) begin
            laneMode = 2'(m);
            repeat (2) begin
                txByte = 8'($random(seed));
                exp_q.push_back(txByte);
                i_sfpi_host_model.xfer(1 << m, txByte, 1'b0, rx);
            end
            outPhase = 1'b1;
            txByte = 8'($random(seed));
            i_sfpi_host_model.xfer(1 << m, txByte, 1'b1, rx);
            check(rx, txByte);
            outPhase = 1'b0;
        end
        $display("test lanes done");
        quadEnableBit = 1'b0;
        exp_q.push_back(8'h3C);
        i_sfpi_host_model.xfer(1, 8'h3C, 1'b0, rx);
        check(8'(quadRefused), 8'h01);
        laneMode = sfpi_pkg::MODE_SINGLE;
        pulse(opStart);
        exp_q.push_back(8'h5A);
        i_sfpi_host_model.xfer(1, 8'h5A, 1'b0, rx);
        check(8'(opBusy), 8'h01);
        pulse(opDone);
        check(8'(opBusy), 8'h00);
        $display("test ops done");
        i_sfpi_host_model.csN = 1'b0;
        i_sfpi_host_model.laneIn = 4'h3;
        repeat (12) @(negedge clk_sys);
        check({6'h00, paused, hwResetActive}, 8'h02);
        pauseResetSel = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({6'h00, paused, hwResetActive}, 8'h01);
        pauseResetSel = 1'b0;
        i_sfpi_host_model.csN = 1'b1;
        statusProtectBits = 2'h1;
        i_sfpi_host_model.laneIn = 4'hB;
        for (int q = 0; q < 2; q++) begin
            quadEnableBit = q[0];
            repeat (8) @(negedge clk_sys);
            statusWrReq = 1'b1;
            @(negedge clk_sys);
            statusWrReq = 1'b0;
            check(8'(statusWrRefused), 8'(q == 0));
        end
        resetPinN = 1'b0;
        repeat (10) @(negedge clk_sys);
        check({6'h00, hwResetActive, opBusy}, 8'h02);
        resetPinN = 1'b1;
        for (int b = 0; b < 8; b += 7) begin
            blockProtect = 3'(b);
            sectorAddr = 12'($random(seed));
            repeat (4) @(negedge clk_sys);
            check(8'(sectorProtected), 8'(b == 7));
        end
        $display("test protect done");
        tally_and_finish();
    end
endmodule : sfpi_pin_front_tb
bind sfpi_pin_front sfpi_pin_front_assertions i_chk (.*);
